// File: core/lfwe_core.sv
// LIN frame and wake-up engine, one channel, with register port
`timescale 1ns/100ps
module lfwe_core import lfwe_pkg::*; (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output      logic [31:0] rdata_o,
   input  wire logic        bus_receive_pin_i,
   output      logic        bus_transmit_o,
   output      logic        chan_irq_o,
   output      logic        low_irq_o
);

   lfwe_state_t q;
   lfwe_state_t n;
   logic        tick;
   logic        bend;
   logic        cmpp;
   logic        halfp;
   logic        fall;
   logic        in_op;
   logic        in_wk;
   logic        infr;
   logic        stop;
   logic        creq;
   logic        ldset;
   logic        isbuf;
   logic [3:0]  last;
   logic [3:0]  hlast;
   logic [3:0]  nlen;
   logic [1:0]  mon;
   logic [5:0]  den;
   logic [5:0]  eset;
   logic [7:0]  tmax;
   logic [4:0]  wthr;

   function automatic logic [7:0] csum_add(input logic [7:0] a,
                                           input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      csum_add = s[7:0] + {7'h00, s[8]};
   endfunction : csum_add

   // Next byte to send and running checksum
   function automatic logic [15:0] load_byte(input logic [3:0] k,
                                             input logic [3:0] nl,
                                             input logic [7:0] cs,
                                             input logic [7:0][7:0] db);
      if (k < nl) begin
         load_byte = {db[k[2:0]], csum_add(cs, db[k[2:0]])};
      end else begin
         load_byte = {~cs, cs};
      end
   endfunction : load_byte

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      n      = q;
      eset   = 6'h00;
      stop   = 1'b0;
      n.irq_c = 1'b0;
      n.irq_l = 1'b0;
      n.rdata = 32'h0000_0000;
      in_op  = (q.mode_request == MODE_OP);
      in_wk  = (q.mode_request == MODE_WAKE);
      mon    = in_op ? MON_OP : (in_wk ? MON_WAKE : MON_RST);
      den    = q.ctl[CTL_DEN +: 6] | ERR_FORCE;
      nlen   = (q.response_length > MAX_LEN) ? MAX_LEN : q.response_length;
      tmax   = TO_BASE + ({4'h0, nlen} + 8'h01) * TO_PER;
      wthr   = {q.wake_receive_threshold, 1'b1};
      isbuf  = (adr_i[7:5] == ADR_BUF[7:5]) && (adr_i[1:0] == 2'h0);

      // Bit engine clock and bit phase
      tick   = (q.pre == q.div);
      n.pre  = tick ? 16'h0000 : q.pre + 16'h0001;
      last   = q.ctl[CTL_OSEL] ? LAST16 : LAST8;
      hlast  = q.ctl[CTL_OSEL] ? HALF16 : HALF8;
      bend   = tick && (q.sub == last);
      cmpp   = tick && (q.sub == (q.ctl[CTL_OSEL] ? CMP16 : CMP8));
      halfp  = tick && ((q.sub == hlast) || (q.sub == last));
      if (tick) begin
         n.sub = bend ? 4'h0 : q.sub + 4'h1;
      end

      // Receive pin synchroniser
      n.sync1 = bus_receive_pin_i;
      n.sync2 = q.sync1;
      n.prev  = q.sync2;
      fall    = q.prev && !q.sync2;
      n.armed = (q.st == ST_WTX) ? 1'b0 : (q.armed | q.sync2);
      n.wcnt  = (q.st == ST_IDLE && in_wk) ? q.wcnt : 5'h00;
      infr    = q.st inside {ST_TXB, ST_RXW, ST_RXV, ST_RXB};
      if (infr && bend) begin
         n.tout = q.tout + 8'h01;
      end

      // Register writes; hardware sets below win over clears
      if (wr_i) begin
         if (adr_i == ADR_MODE) begin
            n.mode_request = wdata_i[1:0];
         end else if (adr_i == ADR_CTL) begin
            n.ctl = wdata_i[13:0];
         end else if (adr_i == ADR_TXC) begin
            n.frame_start_control = q.frame_start_control | wdata_i[0];
         end else if (adr_i == ADR_WAKE) begin
            n.wake_transmit_length   = wdata_i[WK_TXL +: 4];
            n.wake_receive_threshold = wdata_i[WK_RXL +: 4];
         end else if (adr_i == ADR_RESP) begin
            n.response_length    = wdata_i[RS_LEN +: 4];
            n.response_direction = wdata_i[RS_DIR];
         end else if (adr_i == ADR_DIV) begin
            n.div = wdata_i[15:0];
         end else if (adr_i == ADR_STAT) begin
            n.transmit_done_flag = q.transmit_done_flag & wdata_i[S_TXD];
            n.receive_done_flag  = q.receive_done_flag & wdata_i[S_RXD];
            n.first_byte_received_flag =
               q.first_byte_received_flag & wdata_i[S_D1R];
            n.low_edge_flag      = q.low_edge_flag & wdata_i[S_LD];
         end else if (adr_i == ADR_ERR) begin
            n.err = q.err & wdata_i[5:0];
         end else if (isbuf) begin
            n.dbuf[adr_i[4:2]] = wdata_i[7:0];
         end
      end

      // Register reads, data valid in the following cycle
      if (rd_i) begin
         if (adr_i == ADR_MODE) begin
            n.rdata[1:0] = q.mode_request;
         end else if (adr_i == ADR_CTL) begin
            n.rdata[13:0] = q.ctl;
         end else if (adr_i == ADR_TXC) begin
            n.rdata[0] = q.frame_start_control;
         end else if (adr_i == ADR_WAKE) begin
            n.rdata[WK_TXL +: 4] = q.wake_transmit_length;
            n.rdata[WK_RXL +: 4] = q.wake_receive_threshold;
         end else if (adr_i == ADR_RESP) begin
            n.rdata[RS_LEN +: 4] = q.response_length;
            n.rdata[RS_DIR]      = q.response_direction;
         end else if (adr_i == ADR_DIV) begin
            n.rdata[15:0] = q.div;
         end else if (adr_i == ADR_STAT) begin
            n.rdata[S_TXD]      = q.transmit_done_flag;
            n.rdata[S_RXD]      = q.receive_done_flag;
            n.rdata[S_D1R]      = q.first_byte_received_flag;
            n.rdata[S_LD]       = q.low_edge_flag;
            n.rdata[S_ERR]      = |q.err;
            n.rdata[S_MON +: 2] = mon;
         end else if (adr_i == ADR_ERR) begin
            n.rdata[5:0] = q.err;
         end else if (isbuf) begin
            n.rdata[7:0] = q.dbuf[adr_i[4:2]];
         end
      end

      // Frame and wake-up sequencing
      case (q.st)
         ST_IDLE: begin
            if (q.frame_start_control && in_wk) begin
               n.st   = ST_WTX;
               n.sub  = 4'h0;
               n.pre  = 16'h0000;
               n.bidx = 4'h0;
               n.mism = 1'b0;
               n.tx   = 1'b0;
               n.wcnt = 5'h00;
            end else if (q.frame_start_control && in_op) begin
               n.tout = 8'h00;
               n.bno  = 4'h0;
               n.csum = 8'h00;
               n.sub  = 4'h0;
               n.pre  = 16'h0000;
               n.bidx = 4'h0;
               n.mism = 1'b0;
               if (!q.response_direction) begin
                  n.st = ST_RXW;
               end else if (!q.sync2 && den[E_PHY]) begin
                  eset[E_PHY] = 1'b1;
                  stop = 1'b1;
               end else begin
                  n.st = ST_TXB;
                  n.tx = 1'b0;
                  {n.shreg, n.csum} = load_byte(4'h0, nlen, 8'h00, q.dbuf);
               end
            end else if (in_wk && q.armed && halfp) begin
               if (q.sync2) begin
                  n.wcnt = 5'h00;
               end else begin
                  n.wcnt = q.wcnt + ((&q.wcnt) ? 5'h00 : 5'h01);
                  if (q.wcnt == wthr - 5'h01) begin
                     n.receive_done_flag = 1'b1;
                  end
               end
            end
         end
         ST_TXB: begin
            if (cmpp && (q.sync2 != q.tx) && den[E_BIT]) begin
               eset[E_BIT] = 1'b1;
               n.mism = 1'b1;
               if (q.bidx == 4'h0 && den[E_PHY]) begin
                  eset[E_PHY] = 1'b1;
               end
            end
            if (bend) begin
               n.bidx = q.bidx + 4'h1;
               if (q.bidx == 4'h0) begin
                  n.tx = q.shreg[0];
               end else if (q.bidx < 4'h8) begin
                  n.shreg = q.shreg >> 1;
                  n.tx    = q.shreg[1];
               end else if (q.bidx == 4'h8) begin
                  n.tx = 1'b1;
               end else if (q.mism) begin
                  stop = 1'b1;
               end else if (q.bno == nlen) begin
                  n.transmit_done_flag = 1'b1;
                  stop = 1'b1;
               end else begin
                  n.bno  = q.bno + 4'h1;
                  n.bidx = 4'h0;
                  n.tx   = 1'b0;
                  {n.shreg, n.csum} =
                     load_byte(q.bno + 4'h1, nlen, q.csum, q.dbuf);
               end
            end
         end
         ST_RXW: begin
            if (fall) begin
               n.st  = ST_RXV;
               n.sub = 4'h0;
               n.pre = 16'h0000;
            end
         end
         ST_RXV: begin
            if (tick && q.sub == hlast) begin
               if (q.sync2) begin
                  n.st = ST_RXW;
               end else begin
                  n.st   = ST_RXB;
                  n.sub  = 4'h0;
                  n.bidx = 4'h0;
               end
            end
         end
         ST_RXB: begin
            if (bend) begin
               if (q.bidx < 4'h8) begin
                  n.shreg = {q.sync2, q.shreg[7:1]};
                  n.bidx  = q.bidx + 4'h1;
               end else if (!q.sync2 && den[E_FRM]) begin
                  eset[E_FRM] = 1'b1;
                  stop = 1'b1;
               end else if (q.bno == nlen) begin
                  if (q.shreg != ~q.csum) begin
                     eset[E_CSUM] = 1'b1;
                  end else begin
                     n.receive_done_flag = 1'b1;
                  end
                  stop = 1'b1;
               end else if (q.bno == 4'h0 && q.receive_done_flag &&
                            den[E_OVR]) begin
                  eset[E_OVR] = 1'b1;
                  stop = 1'b1;
               end else begin
                  n.dbuf[q.bno[2:0]] = q.shreg;
                  n.csum = csum_add(q.csum, q.shreg);
                  n.bno  = q.bno + 4'h1;
                  n.st   = ST_RXW;
                  if (q.bno == 4'h0) begin
                     n.first_byte_received_flag = 1'b1;
                  end
               end
            end
         end
         ST_WTX: begin
            if (cmpp && q.sync2 && den[E_BIT]) begin
               eset[E_BIT] = 1'b1;
               n.mism = 1'b1;
            end
            if (bend) begin
               n.bidx = q.bidx + 4'h1;
               if (q.mism) begin
                  stop = 1'b1;
               end else if (q.bidx == q.wake_transmit_length) begin
                  n.transmit_done_flag = 1'b1;
                  stop = 1'b1;
               end
            end
         end
         default: begin
            stop = 1'b1;
         end
      endcase

      if (infr && in_op && q.tout == tmax && den[E_TOUT]) begin
         eset[E_TOUT] = 1'b1;
         stop = 1'b1;
      end
      if (stop) begin
         n.st = ST_IDLE;
         n.frame_start_control = 1'b0;
         n.tx = 1'b1;
      end
      n.err = n.err | eset;
      if (!in_op && !in_wk) begin
         n.st   = ST_IDLE;
         n.frame_start_control = 1'b0;
         n.tx   = 1'b1;
         n.prev = 1'b0;
      end

      // Low-edge catch and interrupt requests
      ldset   = q.ctl[CTL_LDE] && !q.sync2 && (q.lhist || !q.lde_p);
      n.lhist = q.sync2;
      n.lde_p = q.ctl[CTL_LDE];
      if (ldset) begin
         n.low_edge_flag = 1'b1;
      end
      creq = (q.transmit_done_flag & q.ctl[CTL_TXIE]) |
             (q.receive_done_flag & q.ctl[CTL_RXIE]) |
             ((|q.err) & q.ctl[CTL_ERIE]);
      n.creq_p = creq;
      n.irq_c  = creq & !q.creq_p;
      n.ld_p   = q.low_edge_flag;
      n.irq_l  = q.low_edge_flag & !q.ld_p;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         q     <= '0;
         q.st  <= ST_IDLE;
         q.ctl <= RST_CTL;
         q.div <= RST_DIV;
         q.tx  <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign rdata_o        = q.rdata;
   assign bus_transmit_o = q.tx;
   assign chan_irq_o     = q.irq_c;
   assign low_irq_o      = q.irq_l;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_wake_go;
      q.st == ST_IDLE && q.frame_start_control && in_wk;
   endsequence

   sequence s_rx_stop_low;
      q.st == ST_RXB && bend && q.bidx == 4'h8 && !q.sync2 && den[E_FRM];
   endsequence

   a_rx_sync_pipe: assert property (
      !$past(rst_i, 2) |-> q.sync2 == $past(bus_receive_pin_i, 2))
      else $error("receive synchroniser depth wrong");

   a_tx_bit_hold: assert property (
      (q.st == ST_TXB && !bend && !stop && (in_op || in_wk))
      |=> $stable(bus_transmit_o))
      else $error("transmit bit changed inside bit time");

   a_cmp_flag_set: assert property (
      (q.st == ST_TXB && cmpp && q.sync2 != q.tx && den[E_BIT])
      |=> q.err[E_BIT])
      else $error("mismatch not recorded");

   a_start_reject: assert property (
      (q.st == ST_RXV && tick && q.sub == hlast && q.sync2)
      |=> q.st == ST_RXW)
      else $error("start bit accepted on high line");

   a_wake_start: assert property (
      s_wake_go ##1 !rst_i |-> q.st == ST_WTX && !bus_transmit_o)
      else $error("wake pulse did not start low");

   a_wake_abort: assert property (
      (q.st == ST_WTX && bend && q.mism)
      |=> q.st == ST_IDLE && bus_transmit_o && !$rose(q.transmit_done_flag))
      else $error("wake transmit not aborted");

   a_frm_abort: assert property (
      s_rx_stop_low |=> q.st == ST_IDLE && q.err[E_FRM])
      else $error("framing fault not handled");

   a_tx_order: assert property (
      (q.st == ST_TXB && bend && q.bidx == STOP_IX && !q.mism &&
       q.bno < nlen && !(q.tout == tmax && den[E_TOUT]) && (in_op || in_wk))
      |=> q.bno == $past(q.bno) + 4'h1 && !bus_transmit_o)
      else $error("response byte order broken");

   a_timeout_cut: assert property (
      (infr && in_op && q.tout == tmax && den[E_TOUT])
      |=> q.err[E_TOUT] && q.st == ST_IDLE)
      else $error("frame timeout not taken");

   a_chan_irq: assert property (
      $rose(creq) |=> chan_irq_o ##1 !chan_irq_o)
      else $error("channel interrupt pulse wrong");

   a_mode_mon: assert property (
      (rd_i && adr_i == ADR_STAT && in_wk)
      |=> rdata_o[S_MON +: 2] == MON_WAKE)
      else $error("mode monitor wrong in wake mode");

endmodule : lfwe_core

// File: core/lfwe_pkg.sv
// Constants, types and contract list for the LIN frame and wake-up engine
// Contract
// - Send one serial bit per bit time
// - Compare read-back at clock 5 or 13
// - Two-stage synchroniser on bus receive pin
// - Start bit needs half bit low
// - Sample each data bit once per bit
// - Transmit buffers one to length in order
// - Store received bytes in order at stop
// - Wake frame start drives timed low pulse
// - Wake mismatch aborts right after that bit
// - Low count blocked until bus seen high
// - Wake threshold reached sets receive done
// - Low edge or low enable sets flag
// - Wake transmit aborts running low count
// - Summary fault is OR of six errors
// - First byte flag, never for zero length
// - Mismatch aborts after stop bit
// - Bus low before start is bus stuck
// - Checksum fault detection cannot be disabled
// - Timeout after 50 plus 14 per byte
// - Low stop bit gives framing fault, abort
// - First byte while receive done: overrun
// - Interrupt on enabled flag rise, ORed
// - Mode request and monitor encodings
// - Bit time is 8 or 16 ticks, one tick per divider plus one clocks
package lfwe_pkg;
   localparam logic [7:0]  ADR_MODE = 8'h00;
   localparam logic [7:0]  ADR_CTL  = 8'h04;
   localparam logic [7:0]  ADR_TXC  = 8'h08;
   localparam logic [7:0]  ADR_WAKE = 8'h0c;
   localparam logic [7:0]  ADR_RESP = 8'h10;
   localparam logic [7:0]  ADR_DIV  = 8'h14;
   localparam logic [7:0]  ADR_STAT = 8'h18;
   localparam logic [7:0]  ADR_ERR  = 8'h1c;
   localparam logic [7:0]  ADR_BUF  = 8'h20;
   localparam int          CTL_OSEL = 0;
   localparam int          CTL_TXIE = 1;
   localparam int          CTL_RXIE = 2;
   localparam int          CTL_ERIE = 3;
   localparam int          CTL_LDE  = 4;
   localparam int          CTL_DEN  = 8;
   localparam int          WK_TXL   = 0;
   localparam int          WK_RXL   = 4;
   localparam int          RS_LEN   = 0;
   localparam int          RS_DIR   = 4;
   localparam int          S_TXD    = 0;
   localparam int          S_RXD    = 1;
   localparam int          S_D1R    = 2;
   localparam int          S_LD     = 3;
   localparam int          S_ERR    = 4;
   localparam int          S_MON    = 6;
   localparam int          E_BIT    = 0;
   localparam int          E_PHY    = 1;
   localparam int          E_CSUM   = 2;
   localparam int          E_TOUT   = 3;
   localparam int          E_FRM    = 4;
   localparam int          E_OVR    = 5;
   localparam logic [5:0]  ERR_FORCE = 6'h04;
   localparam logic [13:0] RST_CTL  = 14'h3f00;
   localparam logic [15:0] RST_DIV  = 16'h0103;
   localparam logic [1:0]  MODE_WAKE = 2'h1;
   localparam logic [1:0]  MODE_OP   = 2'h3;
   localparam logic [1:0]  MON_WAKE  = 2'h2;
   localparam logic [1:0]  MON_OP    = 2'h3;
   localparam logic [1:0]  MON_RST   = 2'h0;
   localparam logic [3:0]  LAST8   = 4'h7;
   localparam logic [3:0]  LAST16  = 4'hf;
   localparam logic [3:0]  HALF8   = 4'h3;
   localparam logic [3:0]  HALF16  = 4'h7;
   localparam logic [3:0]  CMP8    = 4'h4;
   localparam logic [3:0]  CMP16   = 4'hc;
   localparam logic [3:0]  MAX_LEN = 4'h8;
   localparam logic [3:0]  STOP_IX = 4'h9;
   localparam logic [7:0]  TO_BASE = 8'd50;
   localparam logic [7:0]  TO_PER  = 8'd14;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_TXB  = 6'b000010,
      ST_RXW  = 6'b000100,
      ST_RXV  = 6'b001000,
      ST_RXB  = 6'b010000,
      ST_WTX  = 6'b100000
   } lfwe_st_t;

   typedef struct packed {
      lfwe_st_t        st;
      logic [1:0]      mode_request;
      logic [13:0]     ctl;
      logic            frame_start_control;
      logic [3:0]      wake_transmit_length;
      logic [3:0]      wake_receive_threshold;
      logic [3:0]      response_length;
      logic            response_direction;
      logic [15:0]     div;
      logic [15:0]     pre;
      logic            transmit_done_flag;
      logic            receive_done_flag;
      logic            first_byte_received_flag;
      logic            low_edge_flag;
      logic [5:0]      err;
      logic [7:0][7:0] dbuf;
      logic [3:0]      sub;
      logic [3:0]      bidx;
      logic [3:0]      bno;
      logic [7:0]      shreg;
      logic [7:0]      csum;
      logic [7:0]      tout;
      logic            mism;
      logic [4:0]      wcnt;
      logic            armed;
      logic            sync1;
      logic            sync2;
      logic            prev;
      logic            lhist;
      logic            lde_p;
      logic            tx;
      logic            creq_p;
      logic            ld_p;
      logic            irq_c;
      logic            irq_l;
      logic [31:0]     rdata;
   } lfwe_state_t;
endpackage : lfwe_pkg

// File: testbench/lfwe_xcvr.sv
// Transceiver and remote node model: wired-AND bus with pull-up
`timescale 1ns/100ps
module lfwe_xcvr (
   input  wire logic tx_i,
   input  wire logic node_low_i,
   output logic      rx_o
);
   // Dominant low from either party, recessive high otherwise
   assign rx_o = tx_i & ~node_low_i;
endmodule : lfwe_xcvr

// File: testbench/tb_top.sv
// Self-checking bench for the LIN frame and wake-up engine
`timescale 1ns/100ps
module tb_top import lfwe_pkg::*; ;
   logic        clock_i;
   logic        rst_i;
   logic [7:0]  adr_i;
   logic [31:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [31:0] rdata_o;
   logic        rx_w;
   logic        bus_transmit_o;
   logic        chan_irq_o;
   logic        low_irq_o;
   logic        node_low;
   int          n_mismatch;
   int          cmp_count;
   int          cyc = 0;

   lfwe_core lfwe_core_inst (.clock_i(clock_i), .rst_i(rst_i), .adr_i(adr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .bus_receive_pin_i(rx_w), .bus_transmit_o(bus_transmit_o),
      .chan_irq_o(chan_irq_o), .low_irq_o(low_irq_o));
   lfwe_xcvr lfwe_xcvr_inst (.tx_i(bus_transmit_o), .node_low_i(node_low),
      .rx_o(rx_w));

   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   task automatic close_out;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr_reg(logic [7:0] a, logic [31:0] d);
      @(posedge clock_i);
      wr_i    <= 1'b1;
      adr_i   <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i    <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] m,
                         logic [31:0] exp);
      @(posedge clock_i);
      rd_i  <= 1'b1;
      adr_i <= a;
      @(posedge clock_i);
      rd_i  <= 1'b0;
      #1 chk(nm, exp, rdata_o & m);
   endtask : rd_chk

   task automatic wait_lvl(logic lvl);
      int n;
      n = 0;
      while (bus_transmit_o !== lvl && n < 3000) begin
         @(posedge clock_i);
         #1 n++;
      end
   endtask : wait_lvl

   // Samples one byte at mid-bit, 32 clocks a bit with divider 3
   task automatic get_byte(logic [7:0] exp);
      logic [9:0] f;
      wait_lvl(1'b0);
      repeat (16) @(posedge clock_i);
      for (int i = 0; i < 10; i++) begin
         #1 f[i] = bus_transmit_o;
         if (i < 9) begin
            repeat (32) @(posedge clock_i);
         end
      end
      chk("tx frame", 32'({1'b1, exp, 1'b0}), 32'(f));
   endtask : get_byte

   task automatic send_byte(logic [7:0] b, logic sb = 1'b1);
      logic [9:0] f;
      f = {sb, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         node_low <= ~f[i];
         repeat (32) @(posedge clock_i);
      end
   endtask : send_byte

   task automatic t_reset_modes;
      logic [1:0] mon [4] = '{2'h0, 2'h2, 2'h0, 2'h3};
      rd_chk("ctl", ADR_CTL, 32'hffffffff, 32'h00003f00);
      rd_chk("div", ADR_DIV, 32'hffffffff, 32'h00000103);
      rd_chk("unmapped", 8'h40, 32'hffffffff, 32'h00000000);
      for (int m = 0; m < 4; m++) begin
         wr_reg(ADR_MODE, 32'(m));
         rd_chk("monitor", ADR_STAT, 32'hc0, {24'h0, mon[m], 6'h0});
      end
   endtask : t_reset_modes

   task automatic t_low_edge;
      int n;
      n = 0;
      wr_reg(ADR_CTL, 32'h3f10);
      node_low <= 1'b1;
      while (low_irq_o !== 1'b1 && n < 20) begin
         @(posedge clock_i);
         #1 n++;
      end
      chk("low irq", 32'h1, 32'(low_irq_o));
      rd_chk("low flag", ADR_STAT, 32'h08, 32'h08);
      node_low <= 1'b0;
      wr_reg(ADR_CTL, 32'h3f00);
      wr_reg(ADR_STAT, 32'h0);
   endtask : t_low_edge

   task automatic t_tx_frame;
      wr_reg(ADR_DIV, 32'h3);
      wr_reg(ADR_MODE, 32'h3);
      wr_reg(ADR_RESP, 32'h11);
      wr_reg(ADR_BUF, 32'ha5);
      wr_reg(ADR_TXC, 32'h1);
      get_byte(8'ha5);
      get_byte(8'h5a);
      repeat (40) @(posedge clock_i);
      rd_chk("tx done", ADR_STAT, 32'h13, 32'h01);
      rd_chk("no error", ADR_ERR, 32'h3f, 32'h00);
      wr_reg(ADR_STAT, 32'h0);
   endtask : t_tx_frame

   task automatic t_rx_frame;
      wr_reg(ADR_RESP, 32'h01);
      wr_reg(ADR_TXC, 32'h1);
      repeat (64) @(posedge clock_i);
      send_byte(8'h3c);
      send_byte(8'hc3);
      repeat (40) @(posedge clock_i);
      rd_chk("buffer 1", ADR_BUF, 32'hff, 32'h3c);
      rd_chk("buffer 2", ADR_BUF + 8'h4, 32'hff, 32'h00);
      rd_chk("rx flags", ADR_STAT, 32'h16, 32'h06);
      // Receive done still set: next first byte overruns
      wr_reg(ADR_TXC, 32'h1);
      repeat (64) @(posedge clock_i);
      send_byte(8'h55);
      repeat (40) @(posedge clock_i);
      rd_chk("overrun", ADR_ERR, 32'h3f, 32'h20);
      rd_chk("summary", ADR_STAT, 32'h10, 32'h10);
      rd_chk("kept 1", ADR_BUF, 32'hff, 32'h3c);
      wr_reg(ADR_STAT, 32'h0);
      wr_reg(ADR_ERR, 32'h0);
      wr_reg(ADR_TXC, 32'h1);
      repeat (64) @(posedge clock_i);
      send_byte(8'h55, 1'b0);
      node_low <= 1'b0;
      repeat (40) @(posedge clock_i);
      rd_chk("framing", ADR_ERR, 32'h3f, 32'h10);
      wr_reg(ADR_ERR, 32'h0);
   endtask : t_rx_frame

   task automatic t_wake_tx(logic [31:0] ctl, int clks);
      int n;
      logic irq;
      n = 0;
      irq = 1'b0;
      wr_reg(ADR_CTL, ctl);
      wr_reg(ADR_MODE, 32'h1);
      wr_reg(ADR_WAKE, 32'h1);
      wr_reg(ADR_TXC, 32'h1);
      wait_lvl(1'b0);
      while (bus_transmit_o === 1'b0 && n < 500) begin
         @(posedge clock_i);
         #1 n++;
      end
      chk("wake low clocks", 32'(clks), 32'(n));
      for (int i = 0; i < 20; i++) begin
         @(posedge clock_i);
         #1 irq = irq | (chan_irq_o === 1'b1);
      end
      chk("wake irq", 32'h1, 32'(irq));
      rd_chk("wake done", ADR_STAT, 32'h01, 32'h01);
      wr_reg(ADR_STAT, 32'h0);
   endtask : t_wake_tx

   // Short low must not wake; 5 bit low must
   task automatic t_wake_rx;
      wr_reg(ADR_CTL, 32'h3f00);
      wr_reg(ADR_WAKE, 32'h30);
      node_low <= 1'b1;
      repeat (64) @(posedge clock_i);
      node_low <= 1'b0;
      repeat (40) @(posedge clock_i);
      rd_chk("short low", ADR_STAT, 32'h02, 32'h00);
      node_low <= 1'b1;
      repeat (160) @(posedge clock_i);
      node_low <= 1'b0;
      repeat (40) @(posedge clock_i);
      rd_chk("wake rx", ADR_STAT, 32'h02, 32'h02);
      wr_reg(ADR_STAT, 32'h0);
   endtask : t_wake_rx

   initial begin
      n_mismatch = 0;
      cmp_count  = 0;
      rst_i      = 1'b1;
      adr_i      = 8'h0;
      wdata_i    = 32'h0;
      wr_i       = 1'b0;
      rd_i       = 1'b0;
      node_low   = 1'b0;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset_modes();
      t_low_edge();
      t_tx_frame();
      t_rx_frame();
      t_wake_tx(32'h3f02, 64);
      t_wake_tx(32'h3f03, 128);
      t_wake_rx();
      close_out();
   end
endmodule : tb_top
